// ### rtl/pirq_flag_regs.v
// peripheral interrupt flag registers with timer pair, capture inputs and bus slave
`timescale 1ns/1ps
`include "pirq_defines.vh"
module pirq_flag_regs #(
    parameter TIMER_W = 8
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire capture_a_pin_in,
    input wire capture_b_pin_in,
    input wire capture_c_pin_in,
    input wire capture_d_pin_in,
    input wire serial_a_tx_empty_in,
    input wire serial_a_rx_full_in,
    input wire serial_b_tx_empty_in,
    input wire serial_b_rx_full_in,
    input wire sync_port_event_in,
    input wire bus_collision_event_in,
    input wire conversion_done_event_in,
    output reg [7:0] rdata_out,
    output reg irq_out,
    output reg [7:0] irq_flags_one_out,
    output reg [7:0] irq_flags_two_out
);
    // pin synchronisers: first stage read only by second
    reg [3:0] cap_s1_q;
    reg [3:0] cap_s2_q;
    reg [3:0] cap_s3_q;
    wire [3:0] cap_rise;
    // timer state
    reg [7:0] ctrl_q;
    reg [TIMER_W-1:0] timer_a_period_q;
    reg [TIMER_W-1:0] timer_b_period_q;
    reg [TIMER_W-1:0] timer_a_count_q;
    reg [TIMER_W-1:0] timer_b_count_q;
    reg [TIMER_W-1:0] timer_a_count_d;
    reg [TIMER_W-1:0] timer_b_count_d;
    reg timer_a_wrap;
    wire timer_pair_wide_select;
    wire timer_run;
    // flag registers
    reg [7:0] flags_one_q;
    reg [7:0] flags_one_d;
    reg [7:0] flags_two_q;
    reg [7:0] flags_two_d;
    // interrupt controller registers
    reg [7:0] irq_status_q;
    reg [7:0] irq_status_d;
    reg [7:0] irq_enable_q;
    wire [7:0] irq_events;
    // capture snapshot memory and register read path
    reg [1:0] snap_waddr;
    reg snap_we;
    wire [15:0] snap_rdata;
    reg [7:0] rd_addr_q;
    reg rd_pending_q;
    reg [7:0] rd_reg_q;
    reg [7:0] rd_mux;
    wire [7:0] snap_base;

    function automatic is_wr;
        input [7:0] a;
        begin
            is_wr = wr_in && (addr_in == a);
        end
    endfunction

    function automatic [7:0] lsb_byte;
        input [TIMER_W-1:0] v;
        reg [15:0] ext;
        begin
            ext = 16'h0000;
            ext[TIMER_W-1:0] = v;
            lsb_byte = ext[7:0];
        end
    endfunction

    assign timer_pair_wide_select = ctrl_q[`PIRQ_CTRL_WIDE];
    assign timer_run = ctrl_q[`PIRQ_CTRL_RUN];
    assign snap_base = `PIRQ_ADDR_SNAP_BASE;
    assign cap_rise = cap_s2_q & ~cap_s3_q;

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cap_s1_q <= 4'h0;
            cap_s2_q <= 4'h0;
            cap_s3_q <= 4'h0;
        end else begin
            cap_s1_q <= {capture_d_pin_in, capture_c_pin_in, capture_b_pin_in,
                         capture_a_pin_in};
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    // timer counting: 8-bit or chained pair
    always @* begin
        timer_a_count_d = timer_a_count_q;
        timer_b_count_d = timer_b_count_q;
        timer_a_wrap = 1'b0;
        if (timer_run) begin
            if (timer_pair_wide_select) begin
                if (timer_a_count_q == timer_a_period_q &&
                    timer_b_count_q == timer_b_period_q) begin
                    timer_a_count_d = {TIMER_W{1'b0}};
                    timer_b_count_d = {TIMER_W{1'b0}};
                    timer_a_wrap = 1'b1;
                end else if (timer_a_count_q == {TIMER_W{1'b1}}) begin
                    timer_a_count_d = {TIMER_W{1'b0}};
                    timer_b_count_d = timer_b_count_q + {{(TIMER_W-1){1'b0}}, 1'b1};
                end else begin
                    timer_a_count_d = timer_a_count_q + {{(TIMER_W-1){1'b0}}, 1'b1};
                end
            end else begin
                if (timer_a_count_q == timer_a_period_q) begin
                    timer_a_count_d = {TIMER_W{1'b0}};
                    timer_a_wrap = 1'b1;
                end else begin
                    timer_a_count_d = timer_a_count_q + {{(TIMER_W-1){1'b0}}, 1'b1};
                end
                if (timer_b_count_q == timer_b_period_q) begin
                    timer_b_count_d = {TIMER_W{1'b0}};
                end else begin
                    timer_b_count_d = timer_b_count_q + {{(TIMER_W-1){1'b0}}, 1'b1};
                end
            end
        end
        if (is_wr(`PIRQ_ADDR_COUNT_A)) begin
            timer_a_count_d = wdata_in[TIMER_W-1:0];
        end
        if (is_wr(`PIRQ_ADDR_COUNT_B)) begin
            timer_b_count_d = wdata_in[TIMER_W-1:0];
        end
    end

    // flag update: hardware set wins over software clear
    always @* begin
        flags_one_d = flags_one_q;
        flags_two_d = flags_two_q;
        if (is_wr(`PIRQ_ADDR_FLAGS_ONE)) begin
            flags_one_d = (flags_one_q & ~`PIRQ_F1_SW_MASK) |
                          (wdata_in & `PIRQ_F1_SW_MASK);
        end
        if (is_wr(`PIRQ_ADDR_FLAGS_TWO)) begin
            flags_two_d = (flags_two_q & ~`PIRQ_F2_SW_MASK) |
                          (wdata_in & `PIRQ_F2_SW_MASK);
        end
        flags_one_d[7:5] = 3'h0;
        if (timer_a_wrap) begin
            flags_one_d[`PIRQ_F1_TIMER_A] = 1'b1;
        end
        if (cap_rise[1]) begin
            flags_one_d[`PIRQ_F1_CAPTURE_B] = 1'b1;
        end
        if (cap_rise[0]) begin
            flags_one_d[`PIRQ_F1_CAPTURE_A] = 1'b1;
        end
        flags_one_d[`PIRQ_F1_SERIAL_A_TX] = serial_a_tx_empty_in;
        flags_one_d[`PIRQ_F1_SERIAL_A_RX] = serial_a_rx_full_in;
        if (sync_port_event_in) begin
            flags_two_d[`PIRQ_F2_SYNC_PORT] = 1'b1;
        end
        if (bus_collision_event_in) begin
            flags_two_d[`PIRQ_F2_BUS_COLL] = 1'b1;
        end
        if (conversion_done_event_in) begin
            flags_two_d[`PIRQ_F2_CONV_DONE] = 1'b1;
        end
        flags_two_d[`PIRQ_F2_UNUSED] = 1'b0;
        if (cap_rise[3]) begin
            flags_two_d[`PIRQ_F2_CAPTURE_D] = 1'b1;
        end
        if (cap_rise[2]) begin
            flags_two_d[`PIRQ_F2_CAPTURE_C] = 1'b1;
        end
        flags_two_d[`PIRQ_F2_SERIAL_B_TX] = serial_b_tx_empty_in;
        flags_two_d[`PIRQ_F2_SERIAL_B_RX] = serial_b_rx_full_in;
    end

    // sticky status: timer, four captures, sync port, collision, conversion
    assign irq_events = {conversion_done_event_in, bus_collision_event_in,
                         sync_port_event_in, cap_rise, timer_a_wrap};

    always @* begin
        irq_status_d = irq_status_q;
        if (is_wr(`PIRQ_ADDR_IRQ_CLEAR)) begin
            irq_status_d = irq_status_q & ~wdata_in;
        end
        irq_status_d = irq_status_d | irq_events;
    end

    always @* begin
        snap_we = |cap_rise;
        snap_waddr = 2'd0;
        if (cap_rise[3]) begin
            snap_waddr = 2'd3;
        end else if (cap_rise[2]) begin
            snap_waddr = 2'd2;
        end else if (cap_rise[1]) begin
            snap_waddr = 2'd1;
        end
    end

    pirq_snap_mem #(
        .DEPTH(4),
        .AW(2),
        .DW(16)
    ) u_snap (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(snap_we),
        .wr_addr_in(snap_waddr),
        .wr_data_in({lsb_byte(timer_b_count_q), lsb_byte(timer_a_count_q)}),
        .rd_addr_in(addr_in[2:1]),
        .rd_data_out(snap_rdata)
    );

    // register read mux, sampled at the strobe edge
    always @* begin
        case (addr_in)
            `PIRQ_ADDR_FLAGS_ONE: rd_mux = flags_one_q;
            `PIRQ_ADDR_FLAGS_TWO: rd_mux = flags_two_q & ~8'h10;
            `PIRQ_ADDR_TIMER_CTRL: rd_mux = ctrl_q;
            `PIRQ_ADDR_PERIOD_A: rd_mux = lsb_byte(timer_a_period_q);
            `PIRQ_ADDR_PERIOD_B: rd_mux = lsb_byte(timer_b_period_q);
            `PIRQ_ADDR_COUNT_A: rd_mux = lsb_byte(timer_a_count_q);
            `PIRQ_ADDR_COUNT_B: rd_mux = lsb_byte(timer_b_count_q);
            `PIRQ_ADDR_IRQ_STATUS: rd_mux = irq_status_q;
            `PIRQ_ADDR_IRQ_ENABLE: rd_mux = irq_enable_q;
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= 8'h00;
            timer_a_period_q <= {TIMER_W{1'b1}};
            timer_b_period_q <= {TIMER_W{1'b1}};
            timer_a_count_q <= {TIMER_W{1'b0}};
            timer_b_count_q <= {TIMER_W{1'b0}};
            flags_one_q <= 8'h00;
            flags_two_q <= `PIRQ_F2_RESET;
            irq_status_q <= 8'h00;
            irq_enable_q <= 8'h00;
            rd_addr_q <= 8'h00;
            rd_pending_q <= 1'b0;
            rd_reg_q <= 8'h00;
            irq_out <= 1'b0;
            irq_flags_one_out <= 8'h00;
            irq_flags_two_out <= `PIRQ_F2_RESET;
        end else begin
            if (is_wr(`PIRQ_ADDR_TIMER_CTRL)) begin
                ctrl_q <= wdata_in & 8'h03;
            end
            if (is_wr(`PIRQ_ADDR_PERIOD_A)) begin
                timer_a_period_q <= wdata_in[TIMER_W-1:0];
            end
            if (is_wr(`PIRQ_ADDR_PERIOD_B)) begin
                timer_b_period_q <= wdata_in[TIMER_W-1:0];
            end
            if (is_wr(`PIRQ_ADDR_IRQ_ENABLE)) begin
                irq_enable_q <= wdata_in;
            end
            timer_a_count_q <= timer_a_count_d;
            timer_b_count_q <= timer_b_count_d;
            flags_one_q <= flags_one_d;
            flags_two_q <= flags_two_d;
            irq_status_q <= irq_status_d;
            rd_addr_q <= addr_in;
            rd_pending_q <= rd_in;
            rd_reg_q <= rd_mux;
            irq_out <= |(irq_status_d & irq_enable_q);
            irq_flags_one_out <= flags_one_d;
            irq_flags_two_out <= flags_two_d;
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise;
    // snapshot bytes come from the memory's own output register
    always @* begin
        if (!rd_pending_q) begin
            rdata_out = 8'h00;
        end else if (rd_addr_q[7:3] == snap_base[7:3]) begin
            rdata_out = rd_addr_q[0] ? snap_rdata[15:8] : snap_rdata[7:0];
        end else begin
            rdata_out = rd_reg_q;
        end
    end
endmodule

// ### rtl/pirq_defines.vh
// register offsets, bit positions and reset values of the peripheral flag block
`ifndef PIRQ_DEFINES_VH
`define PIRQ_DEFINES_VH
`define PIRQ_ADDR_FLAGS_ONE 8'h16
`define PIRQ_ADDR_FLAGS_TWO 8'h10
`define PIRQ_ADDR_TIMER_CTRL 8'h20
`define PIRQ_ADDR_PERIOD_A 8'h21
`define PIRQ_ADDR_PERIOD_B 8'h22
`define PIRQ_ADDR_COUNT_A 8'h23
`define PIRQ_ADDR_COUNT_B 8'h24
`define PIRQ_ADDR_IRQ_STATUS 8'h28
`define PIRQ_ADDR_IRQ_CLEAR 8'h29
`define PIRQ_ADDR_IRQ_ENABLE 8'h2a
`define PIRQ_ADDR_SNAP_BASE 8'h30
`define PIRQ_F1_TIMER_A 4
`define PIRQ_F1_CAPTURE_B 3
`define PIRQ_F1_CAPTURE_A 2
`define PIRQ_F1_SERIAL_A_TX 1
`define PIRQ_F1_SERIAL_A_RX 0
`define PIRQ_F2_SYNC_PORT 7
`define PIRQ_F2_BUS_COLL 6
`define PIRQ_F2_CONV_DONE 5
`define PIRQ_F2_UNUSED 4
`define PIRQ_F2_CAPTURE_D 3
`define PIRQ_F2_CAPTURE_C 2
`define PIRQ_F2_SERIAL_B_TX 1
`define PIRQ_F2_SERIAL_B_RX 0
`define PIRQ_F1_SW_MASK 8'h1c
`define PIRQ_F2_SW_MASK 8'hec
`define PIRQ_F2_RESET 8'h02
`define PIRQ_CTRL_WIDE 0
`define PIRQ_CTRL_RUN 1
`endif

// ### rtl/pirq_snap_mem.v
// small register file that records the timer count for the highest-numbered capture pin that rises in a cycle
`timescale 1ns/1ps
module pirq_snap_mem #(
    parameter DEPTH = 4,
    parameter AW = 2,
    parameter DW = 16
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [DW-1:0] wr_data_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem_q [0:DEPTH-1];
    integer i;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {DW{1'b0}};
            end
            rd_data_out <= {DW{1'b0}};
        end else begin
            if (wr_en_in) begin
                mem_q[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule

// ### verif/pirq_flag_regs_props.sv
// port-level assertions for the peripheral flag block
`timescale 1ns/1ps
module pirq_flag_regs_props #(
    parameter TIMER_W = 8
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire rd_in,
    input wire capture_a_pin_in,
    input wire capture_b_pin_in,
    input wire serial_a_tx_empty_in,
    input wire serial_a_rx_full_in,
    input wire [7:0] rdata_out,
    input wire [7:0] irq_flags_one_out,
    input wire [7:0] irq_flags_two_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_reset_two;
        $rose(rst_n_in) |-> irq_flags_two_out == 8'h02;
    endproperty
    a_reset_two: assert property (p_reset_two) else $error("flags two reset value");
    property p_unused_zero;
        irq_flags_two_out[4] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("flags two bit 4 set");
    property p_unused_read;
        rd_in && addr_in == 8'h10 |=> rdata_out[4] == 1'b0;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("bit 4 read as one");
    property p_tx_set;
        $rose(serial_a_tx_empty_in) |-> ##[1:3] irq_flags_one_out[1];
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx empty flag not set");
    property p_tx_clr;
        $fell(serial_a_tx_empty_in) |-> ##[1:3] !irq_flags_one_out[1];
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx empty flag not cleared");
    property p_rx_set;
        $rose(serial_a_rx_full_in) |-> ##[1:3] irq_flags_one_out[0];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx full flag not set");
    property p_cap_a;
        $rose(capture_a_pin_in) |-> ##[1:6] irq_flags_one_out[2];
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture a flag not set");
    property p_cap_b;
        $rose(capture_b_pin_in) |-> ##[1:6] irq_flags_one_out[3];
    endproperty
    a_cap_b: assert property (p_cap_b) else $error("capture b flag not set");
endmodule

// ### verif/pirq_periph_model.sv
// peripheral side model: capture pins, serial buffer levels and event pulses
`timescale 1ns/1ps
module pirq_periph_model (
    input wire sys_clk_in,
    output reg [3:0] cap_pins_out,
    output reg [3:0] serial_lvl_out,
    output reg [2:0] event_out
);
    initial begin
        cap_pins_out = 4'h0;
        serial_lvl_out = 4'h4;
        event_out = 3'h0;
    end
    // held for three cycles so the pin synchroniser sees it
    task capture(input integer n);
        begin
            @(posedge sys_clk_in);
            cap_pins_out[n] <= 1'b1;
            repeat (3) @(posedge sys_clk_in);
            cap_pins_out[n] <= 1'b0;
        end
    endtask
    task pulse(input integer n);
        begin
            @(posedge sys_clk_in);
            event_out[n] <= 1'b1;
            @(posedge sys_clk_in);
            event_out[n] <= 1'b0;
        end
    endtask
    task serial(input [3:0] lvl);
        begin
            @(posedge sys_clk_in);
            serial_lvl_out <= lvl;
        end
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the peripheral flag block
`timescale 1ns/1ps
module tb_top;
    reg sys_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    wire [3:0] cap;
    wire [3:0] lvl;
    wire [2:0] ev;
    wire [7:0] rdata_out;
    wire irq_out;
    wire [7:0] f1;
    wire [7:0] f2;
    reg [7:0] rv;
    integer error_cnt = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i;
    always #20 sys_clk_in = ~sys_clk_in;
    pirq_periph_model periph (.sys_clk_in(sys_clk_in), .cap_pins_out(cap),
        .serial_lvl_out(lvl), .event_out(ev));
    pirq_flag_regs #(.TIMER_W(8)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .capture_a_pin_in(cap[0]), .capture_b_pin_in(cap[1]), .capture_c_pin_in(cap[2]),
        .capture_d_pin_in(cap[3]), .serial_a_tx_empty_in(lvl[0]),
        .serial_a_rx_full_in(lvl[1]), .serial_b_tx_empty_in(lvl[2]),
        .serial_b_rx_full_in(lvl[3]), .sync_port_event_in(ev[0]),
        .bus_collision_event_in(ev[1]), .conversion_done_event_in(ev[2]),
        .rdata_out(rdata_out), .irq_out(irq_out), .irq_flags_one_out(f1),
        .irq_flags_two_out(f2));
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    always @(posedge sys_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end
    task check(input [39:0] nm, input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task cycles(input integer n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_in);
            wr_in <= 1'b1;
            addr_in <= a;
            wdata_in <= d;
            @(posedge sys_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task rdchk(input [39:0] nm, input [7:0] a, input [7:0] exp);
        begin
            @(posedge sys_clk_in);
            rd_in <= 1'b1;
            addr_in <= a;
            @(posedge sys_clk_in);
            rd_in <= 1'b0;
            #1 rv = rdata_out;
            check(nm, rv, exp);
        end
    endtask
    task t_reset;
        begin
            rdchk("two", 8'h10, 8'h02);
            rdchk("one", 8'h16, 8'h00);
            rdchk("unmap", 8'h7f, 8'h00);
            $display("test reset done");
        end
    endtask
    task t_serial;
        begin
            periph.serial(4'h7);
            cycles(4);
            wr(8'h16, 8'h00);
            rdchk("one", 8'h16, 8'h03);
            periph.serial(4'hc);
            cycles(4);
            rdchk("one", 8'h16, 8'h00);
            rdchk("two", 8'h10, 8'h03);
            periph.serial(4'h4);
            $display("test serial done");
        end
    endtask
    task t_capture;
        for (i = 0; i < 4; i = i + 1) begin
            check("pre", i < 2 ? f1 : f2 & 8'hfd, 8'h00);
            periph.capture(i);
            cycles(6);
            check("cap", i < 2 ? f1 : f2 & 8'hfd, 8'h04 << (i % 2));
            rdchk("stat", 8'h28, 8'h02 << i);
            wr(i < 2 ? 8'h16 : 8'h10, 8'h00);
            wr(8'h29, 8'hff);
            $display("test capture %0d done", i);
        end
    endtask
    task t_two;
        begin
            wr(8'h10, 8'hff);
            rdchk("two", 8'h10, 8'hee);
            wr(8'h10, 8'h00);
            rdchk("two", 8'h10, 8'h02);
            for (i = 0; i < 3; i = i + 1)
                periph.pulse(i);
            cycles(3);
            check("event", f2, 8'he2);
            wr(8'h10, 8'h00);
            wr(8'h29, 8'hff);
            $display("test flags two done");
        end
    endtask
    task t_irq;
        begin
            wr(8'h2a, 8'h00);
            periph.capture(0);
            cycles(6);
            check("irq", irq_out, 8'h00);
            wr(8'h2a, 8'h02);
            cycles(2);
            check("irq", irq_out, 8'h01);
            wr(8'h29, 8'h02);
            cycles(2);
            check("irq", irq_out, 8'h00);
            rdchk("stat", 8'h28, 8'h00);
            wr(8'h16, 8'h00);
            $display("test irq done");
        end
    endtask
    task t_timer(input [7:0] ctl, input [7:0] pa, input [7:0] pb, input integer q, lim);
        begin
            wr(8'h20, 8'h00);
            wr(8'h23, 8'h00);
            wr(8'h24, 8'h00);
            wr(8'h21, pa);
            wr(8'h22, pb);
            wr(8'h16, 8'h00);
            wr(8'h20, ctl);
            cycles(q);
            check("early", f1 & 8'h10, 8'h00);
            i = 0;
            while (f1[4] !== 1'b1 && i < lim) begin
                cycles(1);
                i = i + 1;
            end
            check("wrap", f1 & 8'h10, 8'h10);
            wr(8'h20, 8'h00);
            wr(8'h16, 8'h00);
            $display("test timer %h done", ctl);
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_serial;
        t_capture;
        t_two;
        t_irq;
        t_timer(8'h02, 8'h40, 8'h00, 50, 40);
        t_timer(8'h03, 8'h00, 8'h01, 230, 60);
        end_of_test;
    end
endmodule
bind pirq_flag_regs pirq_flag_regs_props #(.TIMER_W(TIMER_W)) u_props (.sys_clk_in, .rst_n_in,
    .addr_in, .rd_in, .capture_a_pin_in, .capture_b_pin_in, .serial_a_tx_empty_in,
    .serial_a_rx_full_in, .rdata_out, .irq_flags_one_out, .irq_flags_two_out);
